// *** pfcr_defines.vh ***
// offsets, field positions, reset values and timing figures for the
// pin-function and fault-capture register block
// assumes a 20 MHz system clock
`ifndef PFCR_DEFINES_VH
`define PFCR_DEFINES_VH

// register addresses
`define PFCR_ADDR_PIN_FN      8'h20
`define PFCR_ADDR_CAPTURE     8'h21

// pin_function_control fields
`define PFCR_PF_IRQ_EN        6
`define PFCR_PF_P2_DATA       5
`define PFCR_PF_P2_DIR        4
`define PFCR_PF_P2_CTRL       3
`define PFCR_PF_P1_DATA       2
`define PFCR_PF_P1_DIR        1
`define PFCR_PF_P1_CTRL       0
`define PFCR_PF_WMASK         8'h7f
`define PFCR_PF_RESET         8'h00

// fault_flash_code_capture fields
`define PFCR_CAP_LED2_HI      7
`define PFCR_CAP_LED2_LO      4
`define PFCR_CAP_LED1_HI      3
`define PFCR_CAP_LED1_LO      0
`define PFCR_CAP_RESET        8'h00

// configuration register one bits kept here
`define PFCR_CFG1_TORCH_MODE  7
`define PFCR_CFG1_THERM_MODE  4
`define PFCR_CFG1_RESET       8'h00

// unmapped read answer
`define PFCR_RD_UNMAPPED      8'h00

// timing
`define PFCR_CLK_MHZ          20
`define PFCR_MON_DELAY_US     250
`define PFCR_FLASH_DGL_US     8
`define PFCR_MON_DELAY_CYC    (`PFCR_MON_DELAY_US * `PFCR_CLK_MHZ)
`define PFCR_FLASH_DGL_CYC    (`PFCR_FLASH_DGL_US * `PFCR_CLK_MHZ)

`endif

// *** pfcr_deglitch.v ***
// qualifying delay: one-cycle pulse after a condition has held steadily
// assumes cond is already synchronised to clk
`timescale 1ns/10ps
module pfcr_deglitch #(
  parameter CNT_W  = 13,
  parameter CYCLES = 5000
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             cond,
  output reg              fire_ff
);

  reg  [CNT_W-1:0] cnt_ff;
  reg              done_ff;
  wire [CNT_W-1:0] last_cnt;
  wire [31:0]      last_full;

  // terminal count cut to the counter width on purpose
  assign last_full = CYCLES - 1;
  assign last_cnt  = last_full[CNT_W-1:0];

  ////////////////////////////////////////////////////////////////////////////
  // count while condition holds, fire once per assertion
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_ff  <= {CNT_W{1'b0}};
      done_ff <= 1'b0;
      fire_ff <= 1'b0;
    end else if (!cond) begin
      cnt_ff  <= {CNT_W{1'b0}};
      done_ff <= 1'b0;
      fire_ff <= 1'b0;
    end else if (!done_ff && cnt_ff == last_cnt) begin
      done_ff <= 1'b1;
      fire_ff <= 1'b1;
    end else begin
      cnt_ff  <= done_ff ? cnt_ff : cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
      fire_ff <= 1'b0;
    end
  end

endmodule

// *** pfcr_regs.v ***
// pin-function register with its two multiplexed sync pins, and the
// fault flash-code capture register fed by three monitor events
// assumes a byte register port from the serial host interface, comparator
// levels from analog monitors, and LED codes on the same clock
`timescale 1ns/10ps
`include "pfcr_defines.vh"
module pfcr_regs #(
  parameter MON_CYCLES   = `PFCR_MON_DELAY_CYC,
  parameter MON_CNT_W    = 13,
  parameter FLASH_CYCLES = `PFCR_FLASH_DGL_CYC,
  parameter FLASH_CNT_W  = 8
) (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       reg_wr_en,
  input  wire       reg_rd_en,
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  output reg  [7:0] reg_rdata_ff,
  input  wire       cfg_one_wr_en,
  input  wire [7:0] cfg_one_wdata,
  input  wire       flash_event,
  input  wire       supply_mon_enable,
  input  wire       flash_mon_enable,
  input  wire       therm_below_trip,
  input  wire       supply_below_threshold,
  input  wire       supply_below_flash_threshold,
  input  wire [3:0] led_one_code,
  input  wire [3:0] led_two_code,
  input  wire       irq_request,
  input  wire       sync_one_torch_io_pin_in,
  output reg        sync_one_torch_io_pin_out_ff,
  output reg        sync_one_torch_io_pin_oe_n_ff,
  input  wire       sync_two_irq_io_pin_in,
  output reg        sync_two_irq_io_pin_out_ff,
  output reg        sync_two_irq_io_pin_oe_n_ff,
  output reg        rf_sync_input_one_ff,
  output reg        hw_torch_request_ff,
  output reg        rf_sync_input_two_ff,
  output wire       hw_torch_mode,
  output wire       thermistor_mode,
  output wire       therm_flag_strobe,
  output wire       supply_flag_strobe,
  output wire       flash_flag_strobe
);

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  reg  [7:0] pin_fn_ff;
  reg  [7:0] pend_ff;
  reg        pend_valid_ff;
  reg        setup_one_ff;
  reg        setup_two_ff;
  reg  [1:0] in_snap_ff;
  reg  [7:0] capture_ff;
  reg  [7:0] cfg_one_ff;
  reg  [4:0] sync_a_ff;
  reg  [4:0] sync_b_ff;
  reg  [7:0] nxt_rdata;
  reg        nxt_p1_out;
  reg        nxt_p1_oe_n;
  reg        nxt_p2_out;
  reg        nxt_p2_oe_n;

  wire       pf_wr;
  wire       pf_out_one;
  wire       pf_out_two;
  wire       need_double;
  wire       pf_apply;
  wire       irq_mode;
  wire       p1_gpio_out;
  wire       p2_gpio_out;
  wire       pin_one_s;
  wire       pin_two_s;
  wire       therm_s;
  wire       supply_s;
  wire       flash_s;
  wire       any_event;

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // pin is a general-purpose output when direction and control are both 1
  function gpio_out;
    input [7:0] v;
    input       two;
    begin
      if (two) begin
        gpio_out = v[`PFCR_PF_P2_DIR] & v[`PFCR_PF_P2_CTRL];
      end else begin
        gpio_out = v[`PFCR_PF_P1_DIR] & v[`PFCR_PF_P1_CTRL];
      end
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers

  always @(posedge clk) begin
    if (!rst_n) begin
      sync_a_ff <= 5'h00;
      sync_b_ff <= 5'h00;
    end else begin
      sync_a_ff <= {supply_below_flash_threshold, supply_below_threshold,
                    therm_below_trip, sync_two_irq_io_pin_in,
                    sync_one_torch_io_pin_in};
      sync_b_ff <= sync_a_ff;
    end
  end

  assign pin_one_s = sync_b_ff[0];
  assign pin_two_s = sync_b_ff[1];
  assign therm_s   = sync_b_ff[2];
  assign supply_s  = sync_b_ff[3];
  assign flash_s   = sync_b_ff[4];

  //////////////////////////////////////////////////////////////////////////////
  // pin-function register write path

  assign pf_wr       = reg_wr_en && reg_addr == `PFCR_ADDR_PIN_FN;
  assign pf_out_one  = gpio_out(reg_wdata, 1'b0);
  assign pf_out_two  = gpio_out(reg_wdata, 1'b1);
  // a pin newly made an output needs a repeated identical write
  assign need_double = (pf_out_one & ~setup_one_ff)
                     | (pf_out_two & ~setup_two_ff);
  assign pf_apply    = pf_wr && (!need_double
                     || (pend_valid_ff && pend_ff == reg_wdata));

  always @(posedge clk) begin
    if (!rst_n) begin
      pin_fn_ff     <= `PFCR_PF_RESET;
      pend_ff       <= `PFCR_PF_RESET;
      pend_valid_ff <= 1'b0;
      setup_one_ff  <= 1'b0;
      setup_two_ff  <= 1'b0;
      in_snap_ff    <= 2'b00;
    end else begin
      if (pf_wr) begin
        pend_ff       <= reg_wdata;
        pend_valid_ff <= !pf_apply || !need_double;
        in_snap_ff    <= {pin_two_s, pin_one_s};
      end else if (reg_wr_en) begin
        pend_valid_ff <= 1'b0;
      end
      if (pf_apply) begin
        pin_fn_ff    <= reg_wdata & `PFCR_PF_WMASK;
        setup_one_ff <= pf_out_one;
        setup_two_ff <= pf_out_two;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration register one bits

  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_one_ff <= `PFCR_CFG1_RESET;
    end else if (cfg_one_wr_en) begin
      cfg_one_ff <= cfg_one_wdata;
    end else if (flash_event) begin
      cfg_one_ff[`PFCR_CFG1_TORCH_MODE] <= 1'b0;
    end
  end

  assign hw_torch_mode   = cfg_one_ff[`PFCR_CFG1_TORCH_MODE];
  assign thermistor_mode = cfg_one_ff[`PFCR_CFG1_THERM_MODE];

  //////////////////////////////////////////////////////////////////////////////
  // pin drivers and pin functions

  assign irq_mode = pin_fn_ff[`PFCR_PF_IRQ_EN]
                  & pin_fn_ff[`PFCR_PF_P2_DIR]
                  & pin_fn_ff[`PFCR_PF_P2_CTRL];
  assign p1_gpio_out = gpio_out(pin_fn_ff, 1'b0);
  assign p2_gpio_out = gpio_out(pin_fn_ff, 1'b1);

  always @* begin
    nxt_p1_out  = pin_fn_ff[`PFCR_PF_P1_DATA];
    nxt_p1_oe_n = ~p1_gpio_out;
    if (irq_mode) begin
      nxt_p2_out  = 1'b0;
      nxt_p2_oe_n = ~irq_request;
    end else begin
      nxt_p2_out  = pin_fn_ff[`PFCR_PF_P2_DATA];
      nxt_p2_oe_n = ~p2_gpio_out;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      sync_one_torch_io_pin_out_ff  <= 1'b0;
      sync_one_torch_io_pin_oe_n_ff <= 1'b1;
      sync_two_irq_io_pin_out_ff    <= 1'b0;
      sync_two_irq_io_pin_oe_n_ff   <= 1'b1;
      rf_sync_input_one_ff          <= 1'b0;
      hw_torch_request_ff           <= 1'b0;
      rf_sync_input_two_ff          <= 1'b0;
    end else begin
      sync_one_torch_io_pin_out_ff  <= nxt_p1_out;
      sync_one_torch_io_pin_oe_n_ff <= nxt_p1_oe_n;
      sync_two_irq_io_pin_out_ff    <= nxt_p2_out;
      sync_two_irq_io_pin_oe_n_ff   <= nxt_p2_oe_n;
      // control 0 keeps the pin in its sync or torch role
      rf_sync_input_one_ff <= ~pin_fn_ff[`PFCR_PF_P1_CTRL]
                            & ~hw_torch_mode & pin_one_s;
      hw_torch_request_ff  <= ~pin_fn_ff[`PFCR_PF_P1_CTRL]
                            & hw_torch_mode & pin_one_s;
      rf_sync_input_two_ff <= ~pin_fn_ff[`PFCR_PF_P2_CTRL] & pin_two_s;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // event qualification

  pfcr_deglitch #(
    .CNT_W  (MON_CNT_W),
    .CYCLES (MON_CYCLES)
  ) u_therm_delay (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (therm_s & thermistor_mode),
    .fire_ff (therm_flag_strobe)
  );

  pfcr_deglitch #(
    .CNT_W  (MON_CNT_W),
    .CYCLES (MON_CYCLES)
  ) u_supply_delay (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (supply_s & supply_mon_enable),
    .fire_ff (supply_flag_strobe)
  );

  pfcr_deglitch #(
    .CNT_W  (FLASH_CNT_W),
    .CYCLES (FLASH_CYCLES)
  ) u_flash_deglitch (
    .clk     (clk),
    .rst_n   (rst_n),
    .cond    (flash_s & flash_mon_enable),
    .fire_ff (flash_flag_strobe)
  );

  assign any_event = therm_flag_strobe | supply_flag_strobe
                   | flash_flag_strobe;

  //////////////////////////////////////////////////////////////////////////////
  // fault flash-code capture

  always @(posedge clk) begin
    if (!rst_n) begin
      capture_ff <= `PFCR_CAP_RESET;
    end else if (any_event) begin
      capture_ff[`PFCR_CAP_LED2_HI:`PFCR_CAP_LED2_LO] <= led_two_code;
      capture_ff[`PFCR_CAP_LED1_HI:`PFCR_CAP_LED1_LO] <= led_one_code;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read path

  always @* begin
    nxt_rdata = `PFCR_RD_UNMAPPED;
    case (reg_addr)
      `PFCR_ADDR_PIN_FN: begin
        nxt_rdata = pin_fn_ff;
        // input pins report the level caught at the last write
        if (!p1_gpio_out) begin
          nxt_rdata[`PFCR_PF_P1_DATA] = in_snap_ff[0];
        end
        if (!p2_gpio_out) begin
          nxt_rdata[`PFCR_PF_P2_DATA] = in_snap_ff[1];
        end
      end
      `PFCR_ADDR_CAPTURE: begin
        nxt_rdata = capture_ff;
      end
      default: begin
        nxt_rdata = `PFCR_RD_UNMAPPED;
      end
    endcase
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd_en) begin
      reg_rdata_ff <= nxt_rdata;
    end
  end

endmodule

// *** pfcr_regs_sva.sv ***
// assertions on the pin-function and capture register ports
// assumes binding into pfcr_regs with its count parameters
`timescale 1ns/10ps
module pfcr_regs_sva #(
  parameter MON_CYCLES   = 20,
  parameter FLASH_CYCLES = 8
) (
  input wire       clk,
  input wire       rst_n,
  input wire       reg_wr_en,
  input wire       reg_rd_en,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire [7:0] reg_rdata_ff,
  input wire       cfg_one_wr_en,
  input wire       flash_event,
  input wire       supply_mon_enable,
  input wire       flash_mon_enable,
  input wire       therm_below_trip,
  input wire       supply_below_threshold,
  input wire       supply_below_flash_threshold,
  input wire [3:0] led_one_code,
  input wire [3:0] led_two_code,
  input wire       irq_request,
  input wire       sync_two_irq_io_pin_out_ff,
  input wire       sync_two_irq_io_pin_oe_n_ff,
  input wire       hw_torch_mode,
  input wire       thermistor_mode,
  input wire       therm_flag_strobe,
  input wire       supply_flag_strobe,
  input wire       flash_flag_strobe
);
  wire [2:0] stb = {flash_flag_strobe, supply_flag_strobe, therm_flag_strobe};
  wire [2:0] cond = {supply_below_flash_threshold && flash_mon_enable,
                     supply_below_threshold && supply_mon_enable,
                     therm_below_trip && thermistor_mode};
  wire       fn_wr = reg_wr_en && reg_addr == 8'h20;
  wire       out2 = sync_two_irq_io_pin_out_ff;
  wire       oe2_n = sync_two_irq_io_pin_oe_n_ff;
  reg  [7:0] run_ff [0:2];
  reg  [7:0] cap_ff;
  integer    i;
  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    for (i = 0; i < 3; i = i + 1)
      run_ff[i] <= (!rst_n || !cond[i]) ? 8'h00 : run_ff[i] + {7'h00, ~&run_ff[i]};
    cap_ff <= !rst_n ? 8'h00 : (|stb ? {led_two_code, led_one_code} : cap_ff);
  end
  ////////////////////////////////////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_wr(v);
    fn_wr && reg_wdata == v;
  endsequence
  sequence s_pair(v);
    s_wr(v) ##1 (!reg_wr_en)[*2] ##1 s_wr(v);
  endsequence
  property p_late(s, n, c);
    s |-> n >= c && n <= c + 4;
  endproperty
  a_double_write: assert property (s_pair(8'h98) |-> ##2 !oe2_n && !out2)
    else $error("pin two not driven low after double write");
  a_gpio_low: assert property (s_pair(8'h88) |-> ##2 !out2)
    else $error("pin two data not low after double write");
  a_single_write: assert property (s_pair(8'h98) ##1 (!reg_wr_en)[*2] ##1 s_wr(8'hb8)
    |-> ##2 !oe2_n && out2)
    else $error("single write not applied");
  a_irq_output: assert property (s_pair(8'hf8) ##1 (!reg_wr_en)[*2]
    |-> !out2 && oe2_n == !$past(irq_request))
    else $error("pin two not following interrupt");
  a_bit7_zero: assert property (reg_rd_en && reg_addr == 8'h20 |=> !reg_rdata_ff[7])
    else $error("unused bit reads one");
  a_capture_read: assert property (reg_rd_en && reg_addr == 8'h21 && stb == 3'h0
    |=> reg_rdata_ff == $past(cap_ff))
    else $error("capture holds wrong codes");
  a_therm_delay: assert property (p_late(stb[0], run_ff[0], MON_CYCLES))
    else $error("thermistor strobe timing wrong");
  a_supply_delay: assert property (p_late(stb[1], run_ff[1], MON_CYCLES))
    else $error("supply strobe timing wrong");
  a_flash_delay: assert property (p_late(stb[2], run_ff[2], FLASH_CYCLES))
    else $error("flash supply strobe timing wrong");
  a_torch_clear: assert property (flash_event && !cfg_one_wr_en |=> !hw_torch_mode)
    else $error("torch mode kept after flash");
endmodule

bind pfcr_regs pfcr_regs_sva #(.MON_CYCLES(MON_CYCLES), .FLASH_CYCLES(FLASH_CYCLES)) u_sva (.*);

// *** pfcr_pin_model.sv ***
// far side of the two multiplexed pins
// assumes drive enables active low, pin two open drain with pull-up
`timescale 1ns/10ps
module pfcr_pin_model (
  input  wire oe_one_n,
  input  wire out_one,
  input  wire oe_two_n,
  input  wire out_two,
  input  wire ext_one,
  output wire pin_one,
  output wire pin_two
);
  assign pin_one = !oe_one_n ? out_one : ext_one;
  assign pin_two = !oe_two_n ? out_two : 1'b1;
endmodule

// *** pfcr_regs_test.sv ***
// self-checking bench for the pin-function and capture register block
// assumes pfcr_regs, its checker and the pin model compiled first
`timescale 1ns/10ps
module pfcr_regs_test;
  localparam MON = 20;
  reg        clk = 1'b0, rst_n = 1'b0, reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  reg        cfg_one_wr_en = 1'b0, flash_event = 1'b0, irq_request = 1'b0, ext_one = 1'b0;
  reg  [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, cfg_one_wdata = 8'h00, cap = 8'h00;
  reg  [3:0] led_one_code = 4'h0, led_two_code = 4'h0;
  reg  [2:0] cnd = 3'h0, ena = 3'h0;
  wire [7:0] reg_rdata_ff;
  wire [2:0] stb;
  wire       o1, o1n, o2, o2n, p1, p2, torch, therm, s1, t1, s2;
  integer    errors = 0, n_tests = 0, seed = 93774, k, i, got;
  ////////////////////////////////////////////////////////////////////////
  pfcr_regs #(.MON_CYCLES(MON), .MON_CNT_W(5), .FLASH_CYCLES(8), .FLASH_CNT_W(4)) u_dut (
    .clk(clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_ff(reg_rdata_ff),
    .cfg_one_wr_en(cfg_one_wr_en), .cfg_one_wdata(cfg_one_wdata), .flash_event(flash_event),
    .supply_mon_enable(ena[1]), .flash_mon_enable(ena[2]), .therm_below_trip(cnd[0]),
    .supply_below_threshold(cnd[1]), .supply_below_flash_threshold(cnd[2]),
    .led_one_code(led_one_code), .led_two_code(led_two_code), .irq_request(irq_request),
    .sync_one_torch_io_pin_in(p1), .sync_one_torch_io_pin_out_ff(o1),
    .sync_one_torch_io_pin_oe_n_ff(o1n), .sync_two_irq_io_pin_in(p2),
    .sync_two_irq_io_pin_out_ff(o2), .sync_two_irq_io_pin_oe_n_ff(o2n),
    .rf_sync_input_one_ff(s1), .hw_torch_request_ff(t1), .rf_sync_input_two_ff(s2),
    .hw_torch_mode(torch), .thermistor_mode(therm), .therm_flag_strobe(stb[0]),
    .supply_flag_strobe(stb[1]), .flash_flag_strobe(stb[2]));
  pfcr_pin_model u_pins (.oe_one_n(o1n), .out_one(o1), .oe_two_n(o2n), .out_two(o2),
    .ext_one(ext_one), .pin_one(p1), .pin_two(p2));
  ////////////////////////////////////////////////////////////////////////
  always #25 clk = ~clk;
  function [7:0] cap_of(input [3:0] two, input [3:0] one);
    cap_of = {two, one};
  endfunction
  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr_en <= 1'b1;
      @(posedge clk);
      reg_wr_en <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(posedge clk);
      reg_addr <= a;
      reg_rd_en <= 1'b1;
      @(posedge clk);
      reg_rd_en <= 1'b0;
      #1 chk(reg_rdata_ff, exp);
    end
  endtask
  task pin2(input e, input o);
    begin
      @(posedge clk);
      #1 chk({o2n, o2}, {e, o});
    end
  endtask
  task ev(input integer j);
    begin
      @(posedge clk);
      cnd[j] <= 1'b1;
      got = 0;
      for (k = 0; k < MON + 12; k = k + 1) begin
        @(posedge clk);
        #1 if (stb[j] === 1'b1) got = got + 1;
      end
      @(posedge clk);
      cnd[j] <= 1'b0;
      chk(got, j == 0 || ena[j]);
      if (got != 0) cap = cap_of(led_two_code, led_one_code);
      rd(8'h21, cap);
    end
  endtask
  task finish_test;
    begin
      $display("checks %0d errors %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0)
        $display("Simulation passed");
      else
        $display("Simulation failed");
      $finish;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h20, 8'h00);
    rd(8'h21, 8'h00);
    rd(8'h33, 8'h00);
    @(posedge clk);
    ext_one <= 1'b1;
    cfg_one_wdata <= 8'h90;
    cfg_one_wr_en <= 1'b1;
    @(posedge clk);
    cfg_one_wr_en <= 1'b0;
    repeat (4) @(posedge clk);
    #1 chk({t1, s1, s2}, 3'h5);
    @(posedge clk);
    flash_event <= 1'b1;
    @(posedge clk);
    flash_event <= 1'b0;
    #1 chk({torch, therm}, 2'b01);
    repeat (2) @(posedge clk);
    #1 chk({t1, s1, s2}, 3'h3);
    @(posedge clk);
    ext_one <= 1'b0;
    repeat (4) @(posedge clk);
    wr(8'h20, 8'h88);
    pin2(1'b1, 1'b0);
    wr(8'h20, 8'h88);
    pin2(1'b1, 1'b0);
    wr(8'h20, 8'h98);
    pin2(1'b1, 1'b0);
    wr(8'h20, 8'h98);
    pin2(1'b0, 1'b0);
    wr(8'h20, 8'hb8);
    pin2(1'b0, 1'b1);
    rd(8'h20, 8'h38);
    wr(8'h20, 8'hf8);
    pin2(1'b1, 1'b0);
    wr(8'h20, 8'hf8);
    for (i = 0; i < 2; i = i + 1) begin
      @(posedge clk);
      irq_request <= (i == 0);
      repeat (2) @(posedge clk);
      pin2(i == 1, 1'b0);
    end
    wr(8'h20, 8'h01);
    @(posedge clk);
    ext_one <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h20, 8'h21);
    wr(8'h20, 8'h01);
    rd(8'h20, 8'h25);
    wr(8'h20, 8'h07);
    #1 chk({o1n, o1}, 2'b10);
    wr(8'h20, 8'h07);
    @(posedge clk);
    #1 chk({o1n, o1}, 2'b01);
    rd(8'h20, 8'h27);
    for (i = 0; i < 6; i = i + 1) begin
      @(posedge clk);
      {led_two_code, led_one_code} <= 8'($random(seed));
      ena <= (i < 3) ? 3'h7 : 3'($random(seed));
      ev(i % 3);
    end
    finish_test;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    finish_test;
  end
endmodule
